// *** pkg/tmr_clk_pkg.sv ***
/*
 * Constants and carrier types for the timer block clock prescaler and
 * external input sampler.
 * Assumes a single module clock domain; the external pins are asynchronous.
 */
// Contract
// R1 - Every timer block action runs from a basic clock made by the block prescaler.
// R2 - Prescale code 01 divides by 4, 00 by 8, 11 by 16, 10 by 32; reset 00.
// R3 - Timer and gated timer modes count on the per-timer prescaled internal clock.
// R4 - Counter mode counts on transitions detected on the timer's own input pins.
// R5 - Per-timer 3-bit field divides basic clock by two to its power; overall 4 to 4096.
// R6 - Every external input is sampled once per basic clock period.
// R7 - A transition is seen only when two consecutive samples differ.
// R8 - Source holds each input level for one full basic clock period at least.
// R9 - Source keeps input frequency at or below half the basic clock.
// R10 - The hold and frequency limits apply to count, gate and direction inputs.
// R11 - Inputs are synchronised first; edges give one-cycle pulses on the basic enable.
package tmr_clk_pkg;

    // ------------------------------------------------------------
    // Block prescale encodings and division factors
    // ------------------------------------------------------------
    localparam logic [1:0] BPS_DIV8 = 2'h0;
    localparam logic [1:0] BPS_DIV4 = 2'h1;
    localparam logic [1:0] BPS_DIV32 = 2'h2;
    localparam logic [1:0] BPS_DIV16 = 2'h3;
    localparam logic [1:0] BPS_RESET = BPS_DIV8;
    localparam logic [5:0] BLOCK_DIV_4 = 6'h04;
    localparam logic [5:0] BLOCK_DIV_8 = 6'h08;
    localparam logic [5:0] BLOCK_DIV_16 = 6'h10;
    localparam logic [5:0] BLOCK_DIV_32 = 6'h20;

    // ------------------------------------------------------------
    // Widths and timer modes
    // ------------------------------------------------------------
    localparam int NUM_TIMERS = 3;
    localparam int TIP_W = 3;
    localparam int BLK_CNT_W = 5;
    localparam int TIP_CNT_W = 7;
    localparam logic [TIP_W-1:0] TIP_RESET = 3'h0;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_COUNTER
    } timer_mode_t;

    // External inputs of one timer: count, gate and direction.
    typedef struct packed {
        logic count_in;
        logic gate_in;
        logic dir_in;
    } timer_pins_t;

    // Per-timer configuration.
    typedef struct packed {
        timer_mode_t mode;
        logic [TIP_W-1:0] timer_input_prescale;
    } timer_cfg_t;

    // Per-timer sampled state and edge pulses.
    typedef struct packed {
        logic count_level;
        logic gate_level;
        logic dir_level;
        logic count_edge;
        logic gate_edge;
        logic dir_edge;
        logic count_tick;
    } timer_evt_t;

endpackage : tmr_clk_pkg

// *** rtl/pin_sampler.sv ***
/*
 * Synchroniser and basic-clock sampler for one group of external inputs.
 * Assumes samp_en_i is a one-cycle enable on core_clk_i; pins are asynchronous.
 */
`timescale 1ns/1ns
module pin_sampler
    import tmr_clk_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic samp_en_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] edge_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] samp_reg;

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= pin_i; // R11
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Sample per basic period and compare with the previous sample
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    samp_reg[g] <= 1'b0;
                    edge_o[g] <= 1'b0;
                end
                else
                begin
                    edge_o[g] <= samp_en_i && (sync_reg[g] != samp_reg[g]); // R7 R11
                    if (samp_en_i)
                    begin
                        samp_reg[g] <= sync_reg[g]; // R6
                    end
                end
            end
        end
    endgenerate

    assign level_o = samp_reg;

endmodule : pin_sampler

// *** rtl/timer_block_clock_prescaler.sv ***
/*
 * Basic clock generation, per-timer internal count clock and external input
 * sampling for a block of three timers.
 * Assumes configuration comes from control registers elsewhere and that the
 * external sources respect the basic-clock hold and frequency limits.
 */
`timescale 1ns/1ns
module timer_block_clock_prescaler
    import tmr_clk_pkg::*;
#(
    parameter int TIMERS = NUM_TIMERS
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] block_prescale_select_i,
    input timer_cfg_t [TIMERS-1:0] timer_cfg_i,
    input timer_pins_t [TIMERS-1:0] timer_input_pin_i,
    output logic basic_en_o,
    output timer_evt_t [TIMERS-1:0] timer_evt_o
);

    logic [BLK_CNT_W-1:0] blk_cnt_reg;
    logic [BLK_CNT_W-1:0] blk_cnt_next;
    logic [BLK_CNT_W-1:0] blk_last;
    logic basic_en_next;
    logic [1:0] bps_reg;

    // ------------------------------------------------------------
    // Block prescaler
    // ------------------------------------------------------------
    // The select code is not monotonic in the division factor, so it is decoded
    // into a terminal count rather than used as a shift amount.
    always_comb
    begin
        case (bps_reg)
            BPS_DIV4: blk_last = BLK_CNT_W'(BLOCK_DIV_4 - 6'h01); // R2
            BPS_DIV8: blk_last = BLK_CNT_W'(BLOCK_DIV_8 - 6'h01);
            BPS_DIV16: blk_last = BLK_CNT_W'(BLOCK_DIV_16 - 6'h01);
            BPS_DIV32: blk_last = BLK_CNT_W'(BLOCK_DIV_32 - 6'h01);
            default: blk_last = BLK_CNT_W'(BLOCK_DIV_8 - 6'h01);
        endcase
    end

    // A count already past a newly selected terminal value wraps at once
    // instead of running round the full counter.
    always_comb
    begin
        basic_en_next = (blk_cnt_reg >= blk_last);
        blk_cnt_next = basic_en_next ? '0 : blk_cnt_reg + 5'h01;
    end

    // Selection is held locally so the divider sees a stable code.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bps_reg <= BPS_RESET; // R2
        end
        else
        begin
            bps_reg <= block_prescale_select_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            blk_cnt_reg <= '0;
        end
        else
        begin
            blk_cnt_reg <= blk_cnt_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            basic_en_o <= 1'b0;
        end
        else
        begin
            basic_en_o <= basic_en_next; // R1
        end
    end

    // ------------------------------------------------------------
    // Per-timer prescaler and input sampling
    // ------------------------------------------------------------
    genvar t;
    generate
        for (t = 0; t < TIMERS; t++)
        begin : g_timer
            logic [TIP_CNT_W-1:0] tip_cnt_reg;
            logic [TIP_CNT_W-1:0] tip_mask;
            logic tip_wrap;
            logic internal_sel;
            logic external_sel;
            logic tick_reg;
            timer_pins_t lvl;
            timer_pins_t edg;

            // --------------------------------------------------------
            // Count clock source for the selected mode
            // --------------------------------------------------------
            // An unused mode code selects neither source, so the timer sees no ticks.
            // Gated mode is not gated here; the gate level is exported instead.
            always_comb
            begin
                internal_sel = 1'b0;
                external_sel = 1'b0;
                case (timer_cfg_i[t].mode)
                    MODE_TIMER, MODE_GATED:
                    begin
                        internal_sel = 1'b1; // R3
                    end
                    MODE_COUNTER:
                    begin
                        external_sel = 1'b1; // R4
                    end
                    default:
                    begin
                        internal_sel = 1'b0;
                        external_sel = 1'b0;
                    end
                endcase
            end

            // --------------------------------------------------------
            // Per-timer prescaler
            // --------------------------------------------------------
            assign tip_mask = TIP_CNT_W'((8'h01 << timer_cfg_i[t].timer_input_prescale) - 8'h01); // R5
            assign tip_wrap = ((tip_cnt_reg & tip_mask) == tip_mask);

            // The counter restarts whenever the internal clock is not in use, so a
            // return to timer mode always begins with a full prescale period.
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    tip_cnt_reg <= '0;
                end
                else if (!internal_sel)
                begin
                    tip_cnt_reg <= '0;
                end
                else if (basic_en_o)
                begin
                    if (tip_wrap)
                    begin
                        tip_cnt_reg <= '0;
                    end
                    else
                    begin
                        tip_cnt_reg <= tip_cnt_reg + 7'h01;
                    end
                end
            end

            // In counter mode the tick follows the detected count edge by one cycle.
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    tick_reg <= 1'b0;
                end
                else if (internal_sel)
                begin
                    tick_reg <= basic_en_o && tip_wrap; // R3 R5
                end
                else if (external_sel)
                begin
                    tick_reg <= edg.count_in; // R4
                end
                else
                begin
                    tick_reg <= 1'b0;
                end
            end

            // --------------------------------------------------------
            // External input sampling on the basic clock
            // --------------------------------------------------------
            pin_sampler #(
                .WIDTH($bits(timer_pins_t))
            ) u_samp (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .samp_en_i(basic_en_o), // R6 R10
                .pin_i(timer_input_pin_i[t]),
                .level_o(lvl),
                .edge_o(edg)
            );

            // --------------------------------------------------------
            // Event outputs
            // --------------------------------------------------------
            // Levels and edges are registered once more so every output comes from a flip-flop.
            always_ff @(posedge core_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    timer_evt_o[t] <= '0;
                end
                else
                begin
                    timer_evt_o[t].count_level <= lvl.count_in;
                    timer_evt_o[t].gate_level <= lvl.gate_in;
                    timer_evt_o[t].dir_level <= lvl.dir_in;
                    timer_evt_o[t].count_edge <= edg.count_in;
                    timer_evt_o[t].gate_edge <= edg.gate_in;
                    timer_evt_o[t].dir_edge <= edg.dir_in;
                    timer_evt_o[t].count_tick <= tick_reg;
                end
            end
        end
    endgenerate

endmodule : timer_block_clock_prescaler

// *** sim/ext_source.sv ***
/* External pin source: square wave, each level held half_i cycles.
   Assumes half_i is zero (idle) or at least one basic period. */
`timescale 1ns/1ns
module ext_source
    import tmr_clk_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [7:0] half_i,
    output timer_pins_t [NUM_TIMERS-1:0] pins_o
);
    logic [7:0] cnt_reg = 8'h00;
    logic lvl_reg = 1'b0;
    always @(negedge core_clk_i)
    begin
        if (half_i == 8'h00 || cnt_reg + 8'h01 >= half_i)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_reg + 8'h01;
        if (half_i != 8'h00 && cnt_reg + 8'h01 >= half_i)
            lvl_reg <= !lvl_reg;
    end
    assign pins_o = {NUM_TIMERS{lvl_reg, lvl_reg, !lvl_reg}};
endmodule : ext_source

// *** sim/timer_block_clock_prescaler_bench.sv ***
/* Bench for the timer clock prescaler: dividers, tick spacing, counter mode.
   Assumes ext_source drives the pins. */
`timescale 1ns/1ns
module timer_block_clock_prescaler_bench
    import tmr_clk_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] bps = 2'h0;
    timer_cfg_t [NUM_TIMERS-1:0] cfg = '0;
    timer_pins_t [NUM_TIMERS-1:0] pins;
    logic basic_en;
    timer_evt_t [NUM_TIMERS-1:0] evt;
    logic [7:0] half = 8'h00;
    logic [2:0] sig;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int g;
    int fac[4] = '{8, 4, 32, 16};
    assign sig = {evt[1].count_tick, evt[0].count_tick, basic_en};
    always #4 core_clk_i = ~core_clk_i;
    timer_block_clock_prescaler uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .block_prescale_select_i(bps),
        .timer_cfg_i(cfg), .timer_input_pin_i(pins), .basic_en_o(basic_en), .timer_evt_o(evt));
    ext_source src (.core_clk_i(core_clk_i), .half_i(half), .pins_o(pins));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Spacing in cycles between two pulses of one watched signal.
    task gap(input int w);
        while (sig[w] !== 1'b1)
            @(negedge core_clk_i);
        for (g = 1; g < 9000; g++)
        begin
            @(negedge core_clk_i);
            if (sig[w] === 1'b1)
                break;
        end
    endtask : gap
    task t_div;
        for (int c = 0; c < 4; c++)
        begin
            bps = c[1:0];
            gap(0);
            gap(0);
            chk(16'(g), 16'(fac[c]));
        end
    endtask : t_div
    task t_tick;
        bps = 2'h1;
        cfg[1].mode = MODE_GATED;
        for (int n = 0; n < 8; n++)
        begin
            cfg[0].timer_input_prescale = n[2:0];
            gap(1);
            gap(1);
            chk(16'(g), 16'(4 << n));
        end
        gap(2);
        chk(16'(g), 16'h0004);
    endtask : t_tick
    task t_cnt;
        cfg[0].mode = MODE_COUNTER;
        cfg[2].mode = MODE_COUNTER;
        for (int c = 1; c < 3; c++)
        begin
            bps = c[1:0];
            half = 8'(fac[c]);
            gap(1);
            gap(1);
            gap(1);
            chk(16'(g), 16'(fac[c]));
        end
        chk({evt[2].count_tick, evt[0].dir_level ^ evt[0].count_level, evt[0].count_edge}, 16'h0006);
        half = 8'h00;
    endtask : t_cnt
    initial
    begin
        repeat (17) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        t_div();
        t_tick();
        t_cnt();
        wrap_up();
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
endmodule : timer_block_clock_prescaler_bench

// *** sim/timer_block_clock_prescaler_properties.sv ***
/* Checker for the timer clock prescaler, watching timer 0.
   Assumes the ports of the top module only. */
`timescale 1ns/1ns
module timer_block_clock_prescaler_properties
    import tmr_clk_pkg::*;
#(
    parameter int TIMERS = NUM_TIMERS
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] block_prescale_select_i,
    input timer_cfg_t [TIMERS-1:0] timer_cfg_i,
    input timer_pins_t [TIMERS-1:0] timer_input_pin_i,
    input wire logic basic_en_o,
    input timer_evt_t [TIMERS-1:0] timer_evt_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [5:0] gap_reg;
    logic same_reg;
    logic [5:0] need;
    logic [1:0] bps;
    timer_evt_t e0;
    timer_cfg_t c0;
    assign bps = block_prescale_select_i;
    assign e0 = timer_evt_o[0];
    assign c0 = timer_cfg_i[0];
    assign need = bps == 2'h1 ? 6'h03 : bps == 2'h0 ? 6'h07 : bps == 2'h3 ? 6'h0f : 6'h1f;
    // Cycles since the last basic enable, and whether the code held still.
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            gap_reg <= 6'h00;
        else
            gap_reg <= basic_en_o ? 6'h00 : gap_reg + 6'h01;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            same_reg <= 1'b0;
        else if (basic_en_o)
            same_reg <= $stable(bps);
        else if ($changed(bps))
            same_reg <= 1'b0;
    end
    sequence quad_s;
        !basic_en_o [*3] ##1 basic_en_o;
    endsequence
    period_code_a: assert property (basic_en_o && same_reg && $stable(bps) |-> gap_reg == need)
        else $error("basic enable spacing wrong");
    quad_period_a: assert property (basic_en_o && bps == 2'h1 && $stable(bps) |=> quad_s or ##[0:3] $changed(bps))
        else $error("divide by four period wrong");
    edge_timing_a: assert property (e0.count_edge |-> $past(basic_en_o, 2))
        else $error("edge not tied to a sample");
    level_hold_a: assert property (!$past(basic_en_o, 2) |-> $stable(e0.dir_level))
        else $error("level moved between samples");
    change_edge_a: assert property ($changed(e0.gate_level) |-> ##[0:1] e0.gate_edge)
        else $error("level change without edge");
    edge_pulse_a: assert property (e0.dir_edge |=> !e0.dir_edge)
        else $error("edge pulse too long");
    timer_tick_a: assert property (e0.count_tick && c0.mode == MODE_TIMER && $past(c0, 3) == c0 |-> $past(basic_en_o, 2))
        else $error("timer tick off the basic clock");
    every_enable_a: assert property (basic_en_o && c0 == {MODE_TIMER, 3'h0} && $past(c0, 2) == c0 |-> ##2 e0.count_tick)
        else $error("undivided tick missing");
    counter_tick_a: assert property (e0.count_tick && c0.mode == MODE_COUNTER && $past(c0.mode, 3) == MODE_COUNTER |-> $past(e0.count_edge))
        else $error("counter tick without edge");
endmodule : timer_block_clock_prescaler_properties
bind timer_block_clock_prescaler timer_block_clock_prescaler_properties #(.TIMERS(TIMERS)) chk_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .block_prescale_select_i(block_prescale_select_i),
    .timer_cfg_i(timer_cfg_i), .timer_input_pin_i(timer_input_pin_i), .basic_en_o(basic_en_o),
    .timer_evt_o(timer_evt_o));
